// ==== tcs_top.sv ====
// Purpose : type-c status and clear-on-read event flag register bank
// Assumes : status inputs synchronous to clock; classic wishbone slave
// Notes   : event flags also feed a sticky w1c interrupt status with mask
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps

module tcs_top
   import tcs_pkg::*;
#(
   parameter int ADR_W = 8
)
(
   input  wire logic             clock,
   input  wire logic             arst_n,
   input  wire logic             ce,
   // wishbone classic slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic                  wb_ack_o,
   output logic [31:0]           wb_dat_o,
   // type-c status
   input  wire logic [1:0]       active_cc_pin,
   input  wire logic [1:0]       advertised_current_level,
   input  wire logic             vconn_state,
   input  wire logic [2:0]       typec_fsm_state,
   input  wire logic             vbus_safe_zero,
   input  wire logic             detect_abort,
   // monitored conditions
   input  wire logic             system_fault,
   input  wire logic             input_overvolt,
   input  wire logic             current_limit,
   input  wire logic             sys_reg_active,
   input  wire logic             thermal_sd_150,
   input  wire logic             thermal_sd_120,
   input  wire logic             battery_present,
   input  wire logic             weak_charge,
   // interrupt
   output logic                  irq
);

   // ============================================================
   // address decode
   function automatic logic hit(input logic [ADR_W-1:0] adr,
                                input logic [7:0]       idx);
      hit = (adr == ADR_W'({idx, 2'b00}));
   endfunction

   function automatic logic attached(input logic [2:0] st);
      attached = (st == TCS_FSM_UFP) || (st == TCS_FSM_DFP);
   endfunction

   logic       ack_q;
   logic [31:0] dat_q;
   logic       irq_q;
   logic [7:0] stat1_q;
   logic [7:0] stat2_q;
   logic [7:0] evt_q;
   logic [7:0] evt_d;
   logic [7:0] prev_q;
   logic       prime_q;
   logic [7:0] ist_q;
   logic [7:0] ist_d;
   logic [7:0] msk_q;
   logic [7:0] msk_d;

   wire        req     = wb_cyc_i & wb_stb_i & ~ack_q;
   wire        take    = ce & req;
   wire        rd      = take & ~wb_we_i;
   wire        wr      = take & wb_we_i & wb_sel_i[0];
   wire        sel_s1  = hit(wb_adr_i, TCS_IDX_STAT1);
   wire        sel_s2  = hit(wb_adr_i, TCS_IDX_STAT2);
   wire        sel_ev  = hit(wb_adr_i, TCS_IDX_EVT);
   wire        sel_is  = hit(wb_adr_i, TCS_IDX_IST);
   wire        sel_im  = hit(wb_adr_i, TCS_IDX_IMSK);
   wire        rd_ev   = rd & sel_ev;
   wire        wr_is   = wr & sel_is;
   wire        wr_im   = wr & sel_im;

   // ============================================================
   // status capture
   wire [7:0]  stat1_n = {active_cc_pin,
                          advertised_current_level,
                          vconn_state,
                          typec_fsm_state};
   // safe-zero is undefined outside attached states, so read it as zero
   wire        vsafe   = vbus_safe_zero
                         & attached(typec_fsm_state);
   wire [7:0]  stat2_n = {4'h0, vsafe, detect_abort, 2'h0};

   // ============================================================
   // change detection
   wire [7:0]  cond_n  = {system_fault,
                          input_overvolt,
                          current_limit,
                          sys_reg_active,
                          thermal_sd_150,
                          thermal_sd_120,
                          battery_present,
                          weak_charge};
   // the first sample after reset only primes the history, no event
   wire [7:0]  chg     = prime_q ? (cond_n ^ prev_q) : 8'h00;

   // set wins over the clear made by a read in the same cycle
   assign evt_d = (rd_ev ? 8'h00 : evt_q)
                  | chg;

   assign ist_d = (wr_is ? (ist_q & ~wb_dat_i[7:0]) : ist_q) | chg;
   assign msk_d = wr_im ? wb_dat_i[7:0] : msk_q;

   // ============================================================
   // read mux
   wire [7:0]  rd_byte = sel_s1 ? stat1_q :
                         sel_s2 ? stat2_q :
                         sel_ev ? evt_q   :
                         sel_is ? ist_q   :
                         sel_im ? msk_q   : 8'h00;
   // unmapped addresses still ack, with zero data

   // ============================================================
   // registers
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stat1_q <= TCS_RST_BYTE;
         stat2_q <= TCS_RST_BYTE;
         prev_q  <= TCS_RST_BYTE;
         prime_q <= 1'b0;
      end
      else if (ce)
      begin
         stat1_q <= stat1_n;
         stat2_q <= stat2_n;
         prev_q  <= cond_n;
         prime_q <= 1'b1;
      end
   end

   // event flags clear only on a read, istat bits on a w1c write; writes to status and event are dropped
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         evt_q <= TCS_RST_BYTE;
         ist_q <= TCS_RST_BYTE;
         msk_q <= TCS_RST_MASK;
      end
      else if (ce)
      begin
         evt_q <= evt_d;
         ist_q <= ist_d;
         msk_q <= msk_d;
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
         irq_q <= 1'b0;
      end
      else if (ce)
      begin
         ack_q <= req;
         if (rd)
         begin
            dat_q <= {24'h00_0000, rd_byte};
         end
         irq_q <= |(ist_d & msk_d);
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign irq      = irq_q;

   // ============================================================
   // checks
   wire rd_s1 = rd & sel_s1;
   wire rd_s2 = rd & sel_s2;
   wire wr_ro = take & wb_we_i & (sel_s1 | sel_s2 | sel_ev);

   property p_cc_pin;
      @(posedge clock) disable iff (!arst_n)
      rd_s1 |=> wb_dat_o[7:6] == $past(stat1_q[7:6]) && wb_ack_o;
   endproperty
   a_cc_pin: assert property (p_cc_pin)
      else $error("cc pin field not returned in bits 7:6");

   property p_cc_capture;
      @(posedge clock) disable iff (!arst_n)
      ce && active_cc_pin == TCS_CC_ONE |=> stat1_q[7:6] == TCS_CC_ONE;
   endproperty
   a_cc_capture: assert property (p_cc_capture)
      else $error("cc1 active not captured");

   property p_vsafe;
      @(posedge clock) disable iff (!arst_n)
      ce && !attached(typec_fsm_state) |=> !stat2_q[TCS_VSAFE0_BIT];
   endproperty
   a_vsafe: assert property (p_vsafe)
      else $error("safe-zero bit shown outside attached state");

   property p_vsafe_read;
      @(posedge clock) disable iff (!arst_n)
      rd_s2 |=> wb_dat_o[7:0] == $past(stat2_q);
   endproperty
   a_vsafe_read: assert property (p_vsafe_read)
      else $error("status two read data wrong");

   property p_system_fault_set;
      @(posedge clock) disable iff (!arst_n)
      ce && prime_q && (system_fault != prev_q[TCS_EV_SYSTEM_FAULT])
      |=> evt_q[TCS_EV_SYSTEM_FAULT] ##1 (evt_q[TCS_EV_SYSTEM_FAULT] || $past(rd_ev));
   endproperty
   a_system_fault_set: assert property (p_system_fault_set)
      else $error("system fault change not latched");

   property p_ovp_clear;
      @(posedge clock) disable iff (!arst_n)
      rd_ev && !chg[TCS_EV_OVP] |=> !evt_q[TCS_EV_OVP];
   endproperty
   a_ovp_clear: assert property (p_ovp_clear)
      else $error("overvoltage flag not cleared by read");

   property p_current_limit_hold;
      @(posedge clock) disable iff (!arst_n)
      evt_q[TCS_EV_CURRENT_LIMIT] && !rd_ev |=> evt_q[TCS_EV_CURRENT_LIMIT];
   endproperty
   a_current_limit_hold: assert property (p_current_limit_hold)
      else $error("current limit flag lost before read");

   property p_bat_read;
      @(posedge clock) disable iff (!arst_n)
      rd_ev |=> wb_dat_o[TCS_EV_BATTERY_PRESENT] == $past(evt_q[TCS_EV_BATTERY_PRESENT])
               && evt_q[TCS_EV_BATTERY_PRESENT] == $past(chg[TCS_EV_BATTERY_PRESENT]);
   endproperty
   a_bat_read: assert property (p_bat_read)
      else $error("battery flag read or clear wrong");

   property p_ro_write;
      @(posedge clock) disable iff (!arst_n)
      wr_ro && chg == 8'h00 |=> evt_q == $past(evt_q);
   endproperty
   a_ro_write: assert property (p_ro_write)
      else $error("write altered event register");

   property p_irq;
      @(posedge clock) disable iff (!arst_n)
      ce && |(ist_q & msk_q) && !wr_is && !wr_im |=> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("irq low with unmasked status set");

   property p_cc_none;
      @(posedge clock) disable iff (!arst_n)
      ce && active_cc_pin == TCS_CC_NONE |=> stat1_q[7:6] == TCS_CC_NONE;
   endproperty
   a_cc_none: assert property (p_cc_none)
      else $error("no determination code not captured");

   property p_vsafe_attached;
      @(posedge clock) disable iff (!arst_n)
      ce && attached(typec_fsm_state)
      |=> stat2_q[TCS_VSAFE0_BIT] == $past(vbus_safe_zero);
   endproperty
   a_vsafe_attached: assert property (p_vsafe_attached)
      else $error("safe-zero bit lost in attached state");

   property p_system_fault_clear;
      @(posedge clock) disable iff (!arst_n)
      rd_ev && !chg[TCS_EV_SYSTEM_FAULT] |=> !evt_q[TCS_EV_SYSTEM_FAULT];
   endproperty
   a_system_fault_clear: assert property (p_system_fault_clear)
      else $error("system fault flag not cleared by read");

   property p_ovp_set;
      @(posedge clock) disable iff (!arst_n)
      ce && prime_q && (input_overvolt != prev_q[TCS_EV_OVP])
      |=> evt_q[TCS_EV_OVP];
   endproperty
   a_ovp_set: assert property (p_ovp_set)
      else $error("overvoltage change not latched");

   property p_ovp_read;
      @(posedge clock) disable iff (!arst_n)
      rd_ev |=> wb_dat_o[TCS_EV_OVP] == $past(evt_q[TCS_EV_OVP]);
   endproperty
   a_ovp_read: assert property (p_ovp_read)
      else $error("overvoltage flag not returned by read");

   property p_current_limit_set;
      @(posedge clock) disable iff (!arst_n)
      ce && prime_q && (current_limit != prev_q[TCS_EV_CURRENT_LIMIT])
      |=> evt_q[TCS_EV_CURRENT_LIMIT];
   endproperty
   a_current_limit_set: assert property (p_current_limit_set)
      else $error("current limit change not latched");

   property p_current_limit_clear;
      @(posedge clock) disable iff (!arst_n)
      rd_ev && !chg[TCS_EV_CURRENT_LIMIT] |=> !evt_q[TCS_EV_CURRENT_LIMIT];
   endproperty
   a_current_limit_clear: assert property (p_current_limit_clear)
      else $error("current limit flag not cleared by read");

   property p_bat_set;
      @(posedge clock) disable iff (!arst_n)
      ce && prime_q && (battery_present != prev_q[TCS_EV_BATTERY_PRESENT])
      |=> evt_q[TCS_EV_BATTERY_PRESENT];
   endproperty
   a_bat_set: assert property (p_bat_set)
      else $error("battery presence change not latched");

   property p_stat_ro;
      @(posedge clock) disable iff (!arst_n)
      wr_ro |=> stat1_q == $past(stat1_n) && stat2_q == $past(stat2_n);
   endproperty
   a_stat_ro: assert property (p_stat_ro)
      else $error("write altered a status register");

   property p_ack_answer;
      @(posedge clock) disable iff (!arst_n)
      take |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer)
      else $error("request taken without ack next cycle");

   property p_ack_pulse;
      @(posedge clock) disable iff (!arst_n)
      ce && wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack held longer than one cycle");

   property p_freeze;
      @(posedge clock) disable iff (!arst_n)
      !ce |=> evt_q == $past(evt_q) && ist_q == $past(ist_q)
              && wb_ack_o == $past(wb_ack_o);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while clock enable low");

   property p_ist_clear;
      @(posedge clock) disable iff (!arst_n)
      wr_is && chg == 8'h00
      |=> ist_q == ($past(ist_q) & ~$past(wb_dat_i[7:0]));
   endproperty
   a_ist_clear: assert property (p_ist_clear)
      else $error("interrupt status write one clear wrong");

endmodule // tcs_top

// ==== tcs_pkg.sv ====
// Purpose : constants for the type-c status and event flag register bank
// Assumes : classic wishbone slave, 32-bit data, 8-bit registers in low lane
// Notes   : byte address of a register is four times its index
// ============================================================
// Overview of operation
// - active cc pin in status one bits 7:6; 00 none, 01 cc1.
// - vbus safe-zero bit meaningful only in attached source or sink states.
// - system fault change sets event bit 7 until software reads it.
// - input overvoltage change sets event bit 6; a read clears it.
// - current limit change latches event bit 5; reads zero after a read.
// - battery presence change sets event bit 1; read clears it.
// ============================================================
package tcs_pkg;

   // ============================================================
   // register indices; byte address is four times the index
   localparam logic [7:0] TCS_IDX_STAT1 = 8'h09;
   localparam logic [7:0] TCS_IDX_STAT2 = 8'h0A;
   localparam logic [7:0] TCS_IDX_EVT   = 8'h0B;
   localparam logic [7:0] TCS_IDX_IST   = 8'h10;
   localparam logic [7:0] TCS_IDX_IMSK  = 8'h11;

   // ============================================================
   // field positions
   localparam int TCS_CC_PIN_LSB  = 6;
   localparam int TCS_CUR_LSB     = 4;
   localparam int TCS_VCONN_BIT   = 3;
   localparam int TCS_FSM_LSB     = 0;
   localparam int TCS_VSAFE0_BIT  = 3;
   localparam int TCS_ABORT_BIT   = 2;
   localparam int TCS_EV_SYSTEM_FAULT   = 7;
   localparam int TCS_EV_OVP      = 6;
   localparam int TCS_EV_CURRENT_LIMIT     = 5;
   localparam int TCS_EV_VSYS     = 4;
   localparam int TCS_EV_THRM150  = 3;
   localparam int TCS_EV_THRM120  = 2;
   localparam int TCS_EV_BATTERY_PRESENT   = 1;
   localparam int TCS_EV_WEAKCHG  = 0;

   // ============================================================
   // values after reset
   localparam logic [7:0] TCS_RST_BYTE = 8'h00;
   localparam logic [7:0] TCS_RST_MASK = 8'h00;

   // ============================================================
   // type-c state machine codes
   typedef enum logic [2:0] {
      TCS_FSM_NONE   = 3'h0,
      TCS_FSM_UFP    = 3'h1,
      TCS_FSM_DFP    = 3'h2,
      TCS_FSM_AUDIO  = 3'h3,
      TCS_FSM_DEBUG  = 3'h4,
      TCS_FSM_ERROR  = 3'h5,
      TCS_FSM_DIS    = 3'h6,
      TCS_FSM_RFU    = 3'h7
   } tcs_fsm_type;

   localparam logic [1:0] TCS_CC_NONE = 2'h0;
   localparam logic [1:0] TCS_CC_ONE  = 2'h1;

endpackage : tcs_pkg

// ==== tcs_tb.sv ====
// Purpose : self-checking bench for the type-c status and event register bank
// Assumes : ce high except in its own test; wishbone classic, ack next cycle
// Notes   : condition inputs toggled at the edge, then given three cycles
`timescale 1ns/1ps

// ============================================================
// bench top
module testbench;
   import tcs_pkg::*;
   `define CHK(g, e) begin total_checks++; if ((g) !== (e)) \
      begin err_total++; \
      $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
   logic        clock = 1'b0;
   logic        arst_n = 1'b0;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic        wb_ack_o, irq;
   logic [1:0]  cc = 2'h0, cur = 2'h0;
   logic [2:0]  fsm = 3'h0;
   logic        vconn = 1'b0, vsz = 1'b0, abrt = 1'b0;
   logic        ce = 1'b1;
   logic [7:0]  cond = 8'h00;
   int          err_total = 0, total_checks = 0;
   always #4 clock = ~clock;
   tcs_top dut (.clock(clock), .arst_n(arst_n), .ce(ce),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .active_cc_pin(cc),
      .advertised_current_level(cur), .vconn_state(vconn),
      .typec_fsm_state(fsm), .vbus_safe_zero(vsz), .detect_abort(abrt),
      .system_fault(cond[7]), .input_overvolt(cond[6]),
      .current_limit(cond[5]), .sys_reg_active(cond[4]),
      .thermal_sd_150(cond[3]), .thermal_sd_120(cond[2]),
      .battery_present(cond[1]), .weak_charge(cond[0]), .irq(irq));
   // ============================================================
   // bus cycles
   // master holds the whole request until ack is sampled high
   task wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'h1;
      wb_dat_i <= {24'h0, wd};
      @(posedge clock);
      while (wb_ack_o !== 1'b1 && n < 20)
      begin
         @(posedge clock);
         n++;
      end
      if (n >= 20)
      begin
         err_total++;
         $display("MISMATCH t=%0t no ack", $time);
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask
   task rd_chk(input logic [7:0] adr, input logic [7:0] exp);
      wb(1'b0, adr, 8'h00);
      `CHK(rd, {24'h0, exp})
   endtask
   // flip the monitored conditions set in m, then let the change settle
   task flip(input logic [7:0] m);
      @(posedge clock);
      cond <= cond ^ m;
      repeat (3) @(posedge clock);
   endtask
   // ============================================================
   // scenarios
   task t_reset;
      rd_chk(8'h24, 8'h00);
      rd_chk(8'h28, 8'h00);
      rd_chk(8'h2C, 8'h00);
      rd_chk(8'h40, 8'h00);
      rd_chk(8'h44, 8'h00);
      $display("test reset done");
   endtask
   task t_status;
      logic [1:0] c;
      for (int i = 0; i < 2; i++)
      begin
         c = i[1:0];
         @(posedge clock);
         cc <= c;
         cur <= 2'h2;
         vconn <= 1'b1;
         fsm <= 3'h2;
         repeat (3) @(posedge clock);
         rd_chk(8'h24, {c, 2'h2, 1'b1, 3'h2});
      end
      $display("test status done");
   endtask
   task t_safe0;
      logic [2:0] codes [4];
      codes = '{3'h1, 3'h2, 3'h3, 3'h0};
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clock);
         fsm <= codes[i];
         vsz <= 1'b1;
         abrt <= 1'b1;
         repeat (3) @(posedge clock);
         rd_chk(8'h28, {4'h0, (i < 2), 1'b1, 2'h0});
      end
      $display("test safe zero done");
   endtask
   task t_events;
      logic [7:0] bits [4];
      bits = '{8'h80, 8'h40, 8'h20, 8'h02};
      for (int i = 0; i < 4; i++)
      begin
         flip(bits[i]);
         rd_chk(8'h2C, bits[i]);
         rd_chk(8'h2C, 8'h00);
      end
      flip(8'hE2);
      rd_chk(8'h2C, 8'hE2);
      rd_chk(8'h2C, 8'h00);
      flip(8'h1D);
      rd_chk(8'h2C, 8'h1D);
      rd_chk(8'h2C, 8'h00);
      $display("test events done");
   endtask
   // istat is first cleared by writing all ones; mask picks bit 7 only
   task t_irq;
      wb(1'b1, 8'h40, 8'hFF);
      flip(8'h80);
      `CHK(irq, 1'b0)
      wb(1'b1, 8'h44, 8'h80);
      rd_chk(8'h44, 8'h80);
      `CHK(irq, 1'b1)
      wb(1'b1, 8'h40, 8'h80);
      repeat (2) @(posedge clock);
      `CHK(irq, 1'b0)
      rd_chk(8'h2C, 8'h80);
      $display("test interrupt done");
   endtask
   task t_ro;
      flip(8'h02);
      wb(1'b1, 8'h24, 8'hFF);
      wb(1'b1, 8'h28, 8'hFF);
      wb(1'b1, 8'h2C, 8'hFF);
      rd_chk(8'h24, 8'h68);
      rd_chk(8'h28, 8'h04);
      rd_chk(8'h2C, 8'h02);
      rd_chk(8'h3C, 8'h00);
      $display("test read only done");
   endtask
   // a pulse on a condition while ce is low must leave no trace
   task t_ce;
      @(posedge clock);
      ce <= 1'b0;
      flip(8'h40);
      flip(8'h40);
      @(posedge clock);
      ce <= 1'b1;
      rd_chk(8'h2C, 8'h00);
      rd_chk(8'h40, 8'h02);
      $display("test clock enable done");
   endtask
   // ============================================================
   // verdict
   task final_report;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      #100000;
      err_total++;
      final_report();
   end
   initial
   begin
      repeat (6) @(posedge clock);
      arst_n <= 1'b1;
      repeat (2) @(posedge clock);
      t_reset();
      t_status();
      t_safe0();
      t_events();
      t_irq();
      t_ro();
      t_ce();
      final_report();
   end
endmodule // testbench
